// file: core/iab_apb_master.sv
`timescale 1ns/1ps
module iab_apb_master import iab_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // launch
  input wire logic start,
  input wire logic [1:0] startTgt,
  input wire logic startWrite,
  input wire logic [15:0] startAddr,
  input wire logic [31:0] startData,
  // result
  output iab_tgt_req_t tgtReq,
  output logic doneQ,
  output logic [31:0] rdataQ,
  // targets
  input iab_tgt_rsp_t [3:0] tgtRsp
);
  typedef enum logic [1:0] {M_IDLE, M_SETUP, M_ACCESS} iab_mst_e_t;

  typedef struct packed {
    iab_mst_e_t fsm;
    logic [1:0] tgt;
    iab_tgt_req_t req;
    logic [31:0] rdata;
    logic done;
  } iab_mst_t;

  iab_mst_t st_q, st_d;

  always_comb begin
    st_d = st_q;
    st_d.done = 1'b0;
    case (st_q.fsm)
      M_IDLE: begin
        if (start) begin
          st_d.tgt = startTgt;
          st_d.req.psel = 4'h1 << startTgt;
          st_d.req.pwrite = startWrite;
          st_d.req.paddr = startAddr;
          st_d.req.pwdata = startData;
          st_d.fsm = M_SETUP;
        end
      end
      M_SETUP: begin
        st_d.req.penable = 1'b1;
        st_d.fsm = M_ACCESS;
      end
      M_ACCESS: begin
        // the target may stretch the access for as long as it likes
        if (tgtRsp[st_q.tgt].pready) begin
          if (!st_q.req.pwrite) begin
            st_d.rdata = tgtRsp[st_q.tgt].prdata;
          end
          st_d.req.psel = 4'h0;
          st_d.req.penable = 1'b0;
          st_d.done = 1'b1;
          st_d.fsm = M_IDLE;
        end
      end
      default: begin
        st_d = '0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tgtReq = st_q.req;
  assign doneQ = st_q.done;
  assign rdataQ = st_q.rdata;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  one_target_a: assert property ($onehot0(tgtReq.psel))
    else $error("more than one target selected");
  hold_access_a: assert property (tgtReq.penable && !tgtRsp[st_q.tgt].pready
    |=> tgtReq.penable && $stable(tgtReq.paddr))
    else $error("access dropped before target answered");
endmodule

// file: core/iab_bridge.sv
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
module iab_bridge import iab_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // internal targets
  output iab_tgt_req_t tgtReq,
  input iab_tgt_rsp_t [3:0] tgtRsp,
  // timebase control
  output logic cecTimebaseEnable,
  output logic cecTimebaseSource,
  // display-id memory sequencer
  output logic idMemReloadReq,
  output logic idMemClearReq,
  input wire logic idMemReloadDone
);
  typedef struct packed {
    logic ctrlEn;
    logic ctrlRd;
    logic ctrlAinc;
    logic [1:0] ctrlSel;
    logic [15:0] adr;
    logic [31:0] data;
    logic cecSrc;
    logic cecEn;
    logic clrBit;
    logic reloadBit;
    logic clrArm;
    logic busy;
    logic opRead;
    logic [1:0] opTgt;
    logic [31:0] rdata;
    logic rdy;
    logic err;
  } iab_top_t;

  iab_top_t st_q, st_d;

  logic [9:0] idx;
  logic hit;
  logic setupPh;
  logic accessPh;
  logic wrCtrl, wrAdrLo, wrAdrHi, wrD3, wrMisc;
  logic rdLaunch, wrLaunch, startOp;
  logic [1:0] startTgt;
  logic mDone;
  logic [31:0] mRdata;
  logic [7:0] regVal;

  assign idx = paddr[11:2];
  assign hit = (idx >= IDX_CTRL) && (idx <= IDX_MISC);
  assign setupPh = psel && !penable;
  // the access phase is always one cycle: no register access ever waits
  assign accessPh = psel && penable && st_q.rdy;

  assign wrCtrl = accessPh && pwrite && (idx == IDX_CTRL);
  assign wrAdrLo = accessPh && pwrite && (idx == IDX_ADR_LO);
  assign wrAdrHi = accessPh && pwrite && (idx == IDX_ADR_HI);
  assign wrD3 = accessPh && pwrite && (idx == IDX_DATA3);
  assign wrMisc = accessPh && pwrite && (idx == IDX_MISC);

  // a launch while an access is in flight is dropped, not queued
  assign rdLaunch = wrCtrl && pwdata[CTRL_RD_BIT] && pwdata[CTRL_EN_BIT]
    && !st_q.busy;
  assign wrLaunch = wrD3 && st_q.ctrlEn && (st_q.ctrlSel < TGT_CFG)
    && !st_q.busy;
  assign startOp = rdLaunch || wrLaunch;
  assign startTgt = rdLaunch ? pwdata[CTRL_SEL_LSB +: 2] : st_q.ctrlSel;

  iab_apb_master u_master (
    .clk_sys(clk_sys),
    .reset(reset),
    .start(startOp),
    .startTgt(startTgt),
    .startWrite(wrLaunch),
    .startAddr(st_q.adr),
    .startData({pwdata[7:0], st_q.data[23:0]}),
    .tgtReq(tgtReq),
    .doneQ(mDone),
    .rdataQ(mRdata),
    .tgtRsp(tgtRsp)
  );

  always_comb begin
    case (idx)
      IDX_CTRL: regVal = {3'h0, st_q.ctrlSel, st_q.ctrlAinc, st_q.ctrlRd, st_q.ctrlEn};
      IDX_ADR_LO: regVal = st_q.adr[7:0];
      IDX_ADR_HI: regVal = st_q.adr[15:8];
      IDX_DATA0: regVal = st_q.data[7:0];
      IDX_DATA1: regVal = st_q.data[15:8];
      IDX_DATA2: regVal = st_q.data[23:16];
      IDX_DATA3: regVal = st_q.data[31:24];
      IDX_MISC: regVal = {3'h0, st_q.cecSrc, st_q.cecEn, st_q.clrBit, st_q.reloadBit, 1'h0};
      default: regVal = RST_BYTE;
    endcase
  end

  always_comb begin
    st_d = st_q;
    // bus answer is prepared in the setup cycle
    st_d.rdy = setupPh;
    st_d.err = setupPh && !hit;
    st_d.rdata = (setupPh && !pwrite && hit) ? {24'h00_0000, regVal} : RST_WORD;

    // hardware completion first, so a software write in the same cycle wins
    if (mDone) begin
      st_d.busy = 1'b0;
      if (st_q.opRead) begin
        st_d.data = mRdata;
        st_d.ctrlRd = 1'b0;
      end
      if (st_q.ctrlAinc) begin
        st_d.adr = st_q.adr + ((st_q.opTgt == TGT_RX) ? STEP_RX : STEP_OTHER);
      end
    end
    if (idMemReloadDone && st_q.reloadBit) begin
      st_d.reloadBit = 1'b0;
      st_d.clrBit = 1'b0;
      st_d.clrArm = 1'b0;
    end

    if (wrCtrl) begin
      st_d.ctrlEn = pwdata[CTRL_EN_BIT];
      st_d.ctrlAinc = pwdata[CTRL_AINC_BIT];
      st_d.ctrlSel = pwdata[CTRL_SEL_LSB +: 2];
      // while busy the read-start bit is owned by the running access
      if (!st_q.busy) begin
        st_d.ctrlRd = rdLaunch;
      end
    end
    if (wrAdrLo) begin
      st_d.adr[7:0] = pwdata[7:0];
    end
    if (wrAdrHi) begin
      st_d.adr[15:8] = pwdata[7:0];
    end
    if (accessPh && pwrite && (idx >= IDX_DATA0) && (idx <= IDX_DATA3)) begin
      st_d.data[8 * (idx - IDX_DATA0) +: 8] = pwdata[7:0];
    end
    if (wrMisc) begin
      st_d.cecSrc = pwdata[MISC_CECSRC_BIT];
      st_d.cecEn = pwdata[MISC_CECEN_BIT];
      st_d.clrBit = pwdata[MISC_CLR_BIT];
      // a reload in progress cannot be cancelled by writing zero
      st_d.reloadBit = st_d.reloadBit || pwdata[MISC_RELOAD_BIT];
      if (pwdata[MISC_CLR_BIT] && pwdata[MISC_RELOAD_BIT]) begin
        st_d.clrArm = 1'b1;
      end
    end

    if (startOp) begin
      st_d.busy = 1'b1;
      st_d.opRead = rdLaunch;
      st_d.opTgt = startTgt;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_q <= '0;
      st_q.adr <= RST_ADR;
      st_q.data <= RST_WORD;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.rdata;
  assign pready = st_q.rdy;
  assign pslverr = st_q.err;
  assign cecTimebaseEnable = st_q.cecEn;
  assign cecTimebaseSource = st_q.cecSrc;
  assign idMemReloadReq = st_q.reloadBit;
  assign idMemClearReq = st_q.clrArm;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  target_route_a: assert property (tgtReq.psel != 4'h0
    |-> tgtReq.psel == (4'h1 << st_q.opTgt))
    else $error("indirect access went to the wrong target");

  auto_step_a: assert property (mDone && st_q.ctrlAinc && !wrAdrLo && !wrAdrHi
    |=> st_q.adr == $past(st_q.adr) + (($past(st_q.opTgt) == TGT_RX) ? 16'h0004 : 16'h0001))
    else $error("address step after access is wrong");

  read_result_a: assert property (mDone && st_q.opRead && !(accessPh && pwrite)
    |=> st_q.data == $past(mRdata))
    else $error("read word not placed in data bytes");

  read_launch_a: assert property (rdLaunch
    |=> st_q.ctrlRd ##1 tgtReq.psel != 4'h0 && !tgtReq.pwrite)
    else $error("read start did not launch a read");

  read_clear_a: assert property (mDone && st_q.opRead |=> !st_q.ctrlRd)
    else $error("read-start bit not cleared at completion");

  enable_gate_a: assert property ($rose(st_q.busy) |-> $past(st_q.ctrlEn)
    || $past(rdLaunch))
    else $error("indirect access launched while disabled");

  addr_form_a: assert property ($rose(tgtReq.psel != 4'h0)
    |-> tgtReq.paddr == $past(st_q.adr))
    else $error("indirect address not formed from address bytes");

  write_word_a: assert property (wrLaunch
    |=> ##1 tgtReq.pwrite && tgtReq.pwdata[31:24] == $past(pwdata[7:0], 2))
    else $error("top data byte not driven on indirect write");

  cec_follow_a: assert property (wrMisc |=> cecTimebaseEnable == $past(pwdata[3])
    && cecTimebaseSource == $past(pwdata[4]))
    else $error("timebase controls do not follow written bits");

  clear_pair_a: assert property ($rose(idMemClearReq)
    |-> $past(wrMisc && pwdata[2] && pwdata[1]))
    else $error("memory clear armed without both bits written");

  clear_drop_a: assert property (idMemReloadDone && st_q.reloadBit && !wrMisc
    |=> !st_q.clrBit && !idMemClearReq && !idMemReloadReq)
    else $error("clear or reload bit not dropped after reload");

  ro_target_a: assert property (tgtReq.pwrite && tgtReq.psel != 4'h0
    |-> tgtReq.psel[3:2] == 2'h0)
    else $error("write issued to a read-only target");

  write_issue_a: assert property (wrLaunch |=> st_q.busy && !st_q.opRead)
    else $error("top data byte write did not start an indirect write");

  rd_done_c: cover property (rdLaunch ##[1:20] mDone);
  wr_ainc_c: cover property (wrLaunch && st_q.ctrlAinc ##[1:20] mDone);
  reload_c: cover property (idMemClearReq ##[1:50] idMemReloadDone);
  bad_addr_c: cover property (pslverr);
endmodule

// file: core/iab_pkg.sv
package iab_pkg;
  // register indices; byte address on the bus is four times the index
  localparam logic [9:0] IDX_CTRL = 10'h048;
  localparam logic [9:0] IDX_ADR_LO = 10'h049;
  localparam logic [9:0] IDX_ADR_HI = 10'h04a;
  localparam logic [9:0] IDX_DATA0 = 10'h04b;
  localparam logic [9:0] IDX_DATA1 = 10'h04c;
  localparam logic [9:0] IDX_DATA2 = 10'h04d;
  localparam logic [9:0] IDX_DATA3 = 10'h04e;
  localparam logic [9:0] IDX_MISC = 10'h04f;

  // indirect_access_control fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_RD_BIT = 1;
  localparam int CTRL_AINC_BIT = 2;
  localparam int CTRL_SEL_LSB = 3;

  // bridge_misc_control fields
  localparam int MISC_RELOAD_BIT = 1;
  localparam int MISC_CLR_BIT = 2;
  localparam int MISC_CECEN_BIT = 3;
  localparam int MISC_CECSRC_BIT = 4;

  // target codes
  localparam logic [1:0] TGT_RX = 2'h0;
  localparam logic [1:0] TGT_IDMEM = 2'h1;
  localparam logic [1:0] TGT_CFG = 2'h2;
  localparam logic [1:0] TGT_DIEID = 2'h3;

  localparam logic [15:0] STEP_RX = 16'h0004;
  localparam logic [15:0] STEP_OTHER = 16'h0001;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_ADR = 16'h0000;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  typedef struct packed {
    logic [3:0] psel;
    logic penable;
    logic pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
  } iab_tgt_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
  } iab_tgt_rsp_t;
endpackage

// file: tb/iab_tgt_model.sv
`timescale 1ns/1ps
module iab_tgt_model import iab_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // bridge side
  input iab_tgt_req_t tgtReq,
  output iab_tgt_rsp_t [3:0] tgtRsp,
  output int wrCount
);
  logic [31:0] mem [2][64];
  int waitQ;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      waitQ <= 0;
      wrCount <= 0;
      tgtRsp <= '0;
    end else begin
      for (int t = 0; t < 4; t++) begin
        tgtRsp[t].pready <= 1'b0;
        // between answers the data lines invert every cycle, so they hold the last word on alternate cycles
        tgtRsp[t].prdata <= ~tgtRsp[t].prdata;
        if (tgtReq.psel[t] && tgtReq.penable && !tgtRsp[t].pready) begin
          // odd addresses are answered slowly, after four wait states (three more than even ones)
          if (waitQ < 3 * int'(tgtReq.paddr[0])) begin
            waitQ <= waitQ + 1;
          end else begin
            waitQ <= 0;
            tgtRsp[t].pready <= 1'b1;
            if (tgtReq.pwrite) begin
              wrCount <= wrCount + 1;
              if (t < 2) mem[t[0]][tgtReq.paddr[5:0]] <= tgtReq.pwdata;
            end else if (t < 2) begin
              tgtRsp[t].prdata <= mem[t[0]][tgtReq.paddr[5:0]];
            end else begin
              tgtRsp[t].prdata <= {6'h00, t[1:0], 8'h5a, tgtReq.paddr};
            end
          end
        end
      end
    end
  end
endmodule

// file: tb/indirect_apb_access_bridge_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module indirect_apb_access_bridge_tb import iab_pkg::*; ;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic idMemReloadDone = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic cecTimebaseEnable;
  logic cecTimebaseSource;
  logic idMemReloadReq;
  logic idMemClearReq;
  iab_tgt_req_t tgtReq;
  iab_tgt_rsp_t [3:0] tgtRsp;
  int wrCount;
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [31:0] seed = 32'he46b_b8c5;
  logic [7:0] rdv;
  logic errv;

  iab_bridge i_dut (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tgtReq(tgtReq), .tgtRsp(tgtRsp),
    .cecTimebaseEnable(cecTimebaseEnable), .cecTimebaseSource(cecTimebaseSource),
    .idMemReloadReq(idMemReloadReq), .idMemClearReq(idMemClearReq),
    .idMemReloadDone(idMemReloadDone));
  iab_tgt_model i_tgt (.clk_sys(clk_sys), .reset(reset), .tgtReq(tgtReq),
    .tgtRsp(tgtRsp), .wrCount(wrCount));

  initial begin
    forever #50 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // entered just after a rising edge; an idle edge follows so psel is never set twice at once
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h00_0000, wd};
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    `CHK("pready", 1'b1, pready)
    rdv = prdata[7:0];
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [9:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    `CHK("register", e, rdv)
  endtask

  task automatic setAdr(input logic [15:0] a);
    apb(1'b1, IDX_ADR_LO, a[7:0]);
    apb(1'b1, IDX_ADR_HI, a[15:8]);
  endtask

  task automatic wrWord(input logic [31:0] w);
    for (int i = 0; i < 4; i++) apb(1'b1, IDX_DATA0 + 10'(i), w[8*i +: 8]);
  endtask

  task automatic rdWord(input logic [31:0] w);
    for (int i = 0; i < 4; i++) rd(IDX_DATA0 + 10'(i), w[8*i +: 8]);
  endtask

  task automatic waitRead();
    int n;
    n = 0;
    do begin
      apb(1'b0, IDX_CTRL, 8'h00);
      n++;
    end while (rdv[CTRL_RD_BIT] === 1'b1 && n < 30);
    `CHK("readStart", 1'b0, rdv[CTRL_RD_BIT])
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      test_done();
    end
  end

  initial begin
    logic [15:0] a;
    logic [31:0] w;
    logic [1:0] t;
    int wc;
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    for (int i = 0; i < 8; i++) rd(IDX_CTRL + 10'(i), 8'h00);
    apb(1'b0, 10'h047, 8'h00);
    `CHK("unmapped", 1'b1, errv)
    $display("test registers done");
    for (int v = 0; v < 4; v++) begin
      apb(1'b1, IDX_MISC, 8'(v << 3));
      @(posedge clk_sys);
      `CHK("tbEnable", v[0], cecTimebaseEnable)
      `CHK("tbSource", v[1], cecTimebaseSource)
    end
    apb(1'b1, IDX_MISC, 8'h04);
    @(posedge clk_sys);
    `CHK("clearReq", 1'b0, idMemClearReq)
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, IDX_MISC, k == 0 ? 8'h06 : 8'h02);
      repeat (3) @(posedge clk_sys);
      `CHK("clearReq", k == 0, idMemClearReq)
      `CHK("reloadReq", 1'b1, idMemReloadReq)
      idMemReloadDone <= 1'b1;
      @(posedge clk_sys);
      idMemReloadDone <= 1'b0;
      repeat (2) @(posedge clk_sys);
      `CHK("clearReq", 1'b0, idMemClearReq)
      `CHK("reloadReq", 1'b0, idMemReloadReq)
      rd(IDX_MISC, 8'h00);
    end
    $display("test misc control done");
    for (int i = 0; i < 8; i++) begin
      t = 2'(i);
      w = xs();
      a = w[15:0];
      w = xs();
      apb(1'b1, IDX_CTRL, {3'b000, t, 3'b101});
      setAdr(a);
      wc = wrCount;
      wrWord(w);
      repeat (12) @(posedge clk_sys);
      `CHK("writes", t < 2 ? wc + 1 : wc, wrCount)
      setAdr(a);
      apb(1'b1, IDX_CTRL, {3'b000, t, 3'b111});
      waitRead();
      rdWord(t < 2 ? w : {6'h00, t, 8'h5a, a});
      // reads of the read-only targets step the address as well
      a = a + (t == TGT_RX ? STEP_RX : STEP_OTHER);
      rd(IDX_ADR_LO, a[7:0]);
      rd(IDX_ADR_HI, a[15:8]);
    end
    $display("test indirect access done");
    apb(1'b1, IDX_CTRL, 8'h02);
    wc = wrCount;
    wrWord(xs());
    repeat (12) @(posedge clk_sys);
    `CHK("tgtSelect", 4'h0, tgtReq.psel)
    `CHK("writes", wc, wrCount)
    rd(IDX_CTRL, 8'h00);
    $display("test disabled done");
    test_done();
  end
endmodule
